// [data_unit.sv]
// Execution unit for bit judge, mean, annunciator, square root and float conversion.
`timescale 1ns/1ps
`include "data_unit_map.svh"

module data_unit #(
    parameter int TICK_CYCLES = `TICK_CYCLES // Cycles in one 100 ms timer count.
) (
    input wire logic clock, // System clock, 10 MHz.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic op_start, // One-cycle request from the scan engine.
    input wire logic [2:0] op_code, // Operation selector.
    input wire logic [7:0] op_slot, // Instruction instance, for edge memory.
    input wire logic op_drive, // Drive condition of this scan.
    input wire logic op_pulse, // Pulse form when high.
    input wire logic op_wide, // 32-bit form when high.
    input wire logic [31:0] op_src, // Source operand.
    input wire logic [15:0] op_arg, // Bit index, count or preset.
    input wire logic [15:0] op_addr, // Mean start word or timer number.
    input wire logic [6:0] op_target, // Annunciator offset from 900.
    output logic mem_rd, // Device word read strobe.
    output logic [15:0] mem_addr, // Device word address.
    input wire logic [31:0] mem_rdata, // Read data, cycle after strobe.
    output logic done, // Operation finished, one cycle.
    output logic wr_word, // Write res_word to destination.
    output logic wr_bit, // Write res_bit to destination.
    output logic [31:0] res_word, // Word result.
    output logic res_bit, // Bit result.
    output logic instr_error, // Operand out of range, one cycle.
    output logic operation_error_flag, // Square root of a negative.
    output logic borrow_flag, // Fraction discarded.
    output logic zero_flag, // Result was zero.
    output logic any_alarm_active_flag, // Some annunciator state set.
    output logic [15:0] alarm_index_register, // Lowest active state number.
    output logic [`ALARM_COUNT-1:0] alarm_state, // Annunciator states 900-999.
    input wire logic [3:0] reg_addr, // Register word address.
    input wire logic [31:0] reg_wdata, // Register write data.
    input wire logic reg_wr, // Register write strobe.
    input wire logic reg_rd, // Register read strobe.
    output logic [31:0] reg_rdata // Read data, cycle after strobe.
);
    // ----------------------------------------
    // Helpers and decode
    // ----------------------------------------
    sqrt_if sq ();
    float_if fl ();
    int_sqrt u_sqrt (.clock(clock), .rst(rst), .sq(sq.solver));
    int_to_float u_flt (.cv(fl.converter));

    data_unit_pkg::unit_state_t state_r;
    data_unit_pkg::op_code_t code;
    logic [255:0] edge_prev_r;
    logic fire;
    logic monitor_r;
    logic [19:0] tick_cnt_r;
    logic [15:0] now_r;
    logic [`TIMER_COUNT-1:0] run_r;
    logic [15:0] start_r [0:`TIMER_COUNT-1];
    logic [15:0] elapsed;
    logic [6:0] lowest;
    logic any_set;
    logic [6:0] mean_cnt_r;
    logic [6:0] mean_issued_r;
    logic [6:0] mean_got_r;
    logic mean_pend_r;
    logic signed [38:0] mean_acc_r;
    logic signed [38:0] mean_quot;
    logic [31:0] sample;
    logic [16:0] avail;
    logic [6:0] mean_eff;

    assign code = data_unit_pkg::op_code_t'(op_code);
    // Pulse form needs the drive of the previous scan of the same instance.
    assign fire = op_pulse ? (op_drive && !edge_prev_r[op_slot]) : op_drive;
    assign elapsed = now_r - start_r[op_addr[7:0]];
    assign fl.value = op_wide ? op_src : {{16{op_src[15]}}, op_src[15:0]};
    assign sq.start = op_start && fire && (code == data_unit_pkg::OP_SQUARE_ROOT)
                      && !sq.radicand[31] && state_r == data_unit_pkg::ST_IDLE;
    assign sq.radicand = op_wide ? op_src : {{16{op_src[15]}}, op_src[15:0]};
    assign sample = op_wide ? mem_rdata : {{16{mem_rdata[15]}}, mem_rdata[15:0]};
    assign avail = (op_addr < `DEV_WORDS) ? 17'(`DEV_WORDS) - {1'b0, op_addr} : 17'h00000;
    // Words past the end of device memory are left out of the run.
    assign mean_eff = (avail < {10'h000, op_arg[6:0]}) ? avail[6:0] : op_arg[6:0];
    assign mean_quot = mean_acc_r / $signed({32'h0000_0000, mean_got_r});

    // Lowest set annunciator state, scanned from the top down.
    always_comb
    begin
        lowest = 7'h00;
        any_set = 1'b0;
        for (int i = `ALARM_COUNT - 1; i >= 0; i--)
        begin
            if (alarm_state[i])
            begin
                lowest = 7'(i);
                any_set = 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Edge memory and timer base
    // ----------------------------------------
    // Remembers each instance's drive so a pulse fires only on off to on.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            edge_prev_r <= '0;
        else if (op_start)
            edge_prev_r[op_slot] <= op_drive;
    end

    // Free running count of 100 ms units shared by all alarm timers.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            tick_cnt_r <= 20'h00000;
            now_r <= 16'h0000;
        end
        else if (tick_cnt_r == 20'(TICK_CYCLES - 1))
        begin
            tick_cnt_r <= 20'h00000;
            now_r <= now_r + 16'h0001;
        end
        else
        begin
            tick_cnt_r <= tick_cnt_r + 20'h00001;
        end
    end

    // ----------------------------------------
    // Alarm timers and annunciator states
    // ----------------------------------------
    // A timer stores its start time; elapsed time is a wrap-safe difference.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            run_r <= '0;
        else if (op_start && code == data_unit_pkg::OP_ALARM_SET
                 && op_addr <= {8'h00, `TIMER_LAST})
        begin
            if (!op_drive)
                run_r[op_addr[7:0]] <= 1'b0;
            else if (!run_r[op_addr[7:0]])
                run_r[op_addr[7:0]] <= 1'b1;
        end
    end

    // Start times need no reset; they are only read while running.
    always_ff @(posedge clock)
    begin
        if (op_start && code == data_unit_pkg::OP_ALARM_SET && op_drive
            && op_addr <= {8'h00, `TIMER_LAST} && !run_r[op_addr[7:0]])
            start_r[op_addr[7:0]] <= now_r;
    end

    // Set by a timer that ran out, cleared lowest first by alarm reset.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            alarm_state <= '0;
        else if (op_start && code == data_unit_pkg::OP_ALARM_SET && op_drive
                 && op_addr <= {8'h00, `TIMER_LAST} && run_r[op_addr[7:0]]
                 && op_target <= `ALARM_LAST
                 && op_arg != 16'h0000 && op_arg <= `PRESET_MAX
                 && elapsed >= op_arg)
            alarm_state[op_target] <= 1'b1;
        else if (op_start && fire && code == data_unit_pkg::OP_ALARM_RESET && any_set)
            alarm_state[lowest] <= 1'b0;
    end

    // Index and summary follow the states only while monitoring is on.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            alarm_index_register <= 16'h0000;
            any_alarm_active_flag <= 1'b0;
        end
        else if (monitor_r)
        begin
            alarm_index_register <= any_set ? (`ALARM_BASE + {9'h000, lowest}) : 16'h0000;
            any_alarm_active_flag <= any_set;
        end
        else
        begin
            any_alarm_active_flag <= 1'b0;
        end
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // Mean reads one word per cycle; data lands the cycle after each strobe.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state_r <= data_unit_pkg::ST_IDLE;
            mean_cnt_r <= 7'h00;
            mean_issued_r <= 7'h00;
            mean_got_r <= 7'h00;
            mean_pend_r <= 1'b0;
            mean_acc_r <= '0;
            mem_rd <= 1'b0;
            mem_addr <= 16'h0000;
        end
        else
        begin
            mem_rd <= 1'b0;
            mean_pend_r <= mem_rd;
            case (state_r)
                data_unit_pkg::ST_IDLE:
                begin
                    if (op_start && fire && code == data_unit_pkg::OP_MEAN
                        && op_arg != 16'h0000 && op_arg <= {9'h000, `MEAN_MAX}
                        && mean_eff != 7'h00)
                    begin
                        state_r <= data_unit_pkg::ST_MEAN;
                        mean_cnt_r <= mean_eff;
                        mean_issued_r <= 7'h00;
                        mean_got_r <= 7'h00;
                        mean_acc_r <= '0;
                        mem_addr <= op_addr;
                    end
                    else if (sq.start)
                    begin
                        state_r <= data_unit_pkg::ST_SQRT;
                    end
                end
                data_unit_pkg::ST_MEAN:
                begin
                    if (mean_issued_r != mean_cnt_r)
                    begin
                        mem_rd <= 1'b1;
                        mean_issued_r <= mean_issued_r + 7'h01;
                        if (mean_issued_r != 7'h00)
                            mem_addr <= mem_addr + 16'h0001;
                    end
                    if (mean_pend_r)
                    begin
                        mean_acc_r <= mean_acc_r + 39'(signed'(sample));
                        mean_got_r <= mean_got_r + 7'h01;
                    end
                    if (mean_got_r == mean_cnt_r && !mean_pend_r)
                        state_r <= data_unit_pkg::ST_IDLE;
                end
                data_unit_pkg::ST_SQRT:
                begin
                    if (sq.done)
                        state_r <= data_unit_pkg::ST_IDLE;
                end
                default:
                begin
                    state_r <= data_unit_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Results and flags
    // ----------------------------------------
    // One-cycle answer; nothing is written when the drive does not fire.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            done <= 1'b0;
            wr_word <= 1'b0;
            wr_bit <= 1'b0;
            res_word <= 32'h0000_0000;
            res_bit <= 1'b0;
            instr_error <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            wr_word <= 1'b0;
            wr_bit <= 1'b0;
            instr_error <= 1'b0;
            if (state_r == data_unit_pkg::ST_MEAN && mean_got_r == mean_cnt_r && !mean_pend_r)
            begin
                done <= 1'b1;
                wr_word <= 1'b1;
                res_word <= mean_quot[31:0];
            end
            else if (state_r == data_unit_pkg::ST_SQRT && sq.done)
            begin
                done <= 1'b1;
                wr_word <= 1'b1;
                res_word <= {16'h0000, sq.root};
            end
            else if (op_start && state_r == data_unit_pkg::ST_IDLE && !sq.start
                     && !(code == data_unit_pkg::OP_MEAN && fire && !instr_bad_mean()))
            begin
                done <= 1'b1;
                if (fire && code == data_unit_pkg::OP_BIT_JUDGE)
                begin
                    if (op_arg > {10'h000, op_wide ? `BIT_MAX_WIDE : `BIT_MAX_NARROW})
                        instr_error <= 1'b1;
                    else
                    begin
                        wr_bit <= 1'b1;
                        res_bit <= op_src[op_arg[4:0]];
                    end
                end
                else if (fire && code == data_unit_pkg::OP_MEAN)
                    instr_error <= 1'b1;
                else if (code == data_unit_pkg::OP_ALARM_SET)
                    instr_error <= op_drive && (op_addr > {8'h00, `TIMER_LAST}
                        || op_target > `ALARM_LAST || op_arg == 16'h0000
                        || op_arg > `PRESET_MAX);
                else if (fire && code == data_unit_pkg::OP_INT_TO_FLOAT)
                begin
                    wr_word <= 1'b1;
                    res_word <= fl.result;
                end
            end
        end
    end

    // True when a mean request is outside 1 to 64 or starts past memory.
    function automatic logic instr_bad_mean();
        instr_bad_mean = op_arg == 16'h0000 || op_arg > {9'h000, `MEAN_MAX}
                         || mean_eff == 7'h00;
    endfunction : instr_bad_mean

    // Square root flags: error skips the write, the others describe the result.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            operation_error_flag <= 1'b0;
            borrow_flag <= 1'b0;
            zero_flag <= 1'b0;
        end
        else if (op_start && fire && code == data_unit_pkg::OP_SQUARE_ROOT
                 && state_r == data_unit_pkg::ST_IDLE)
        begin
            operation_error_flag <= sq.radicand[31];
        end
        else if (state_r == data_unit_pkg::ST_SQRT && sq.done)
        begin
            borrow_flag <= sq.inexact;
            zero_flag <= (sq.root == 16'h0000);
        end
    end

    // ----------------------------------------
    // Register port
    // ----------------------------------------
    // Only the monitor enable is writable; the rest mirrors unit state.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            monitor_r <= 1'(`CTRL_RESET >> `CTRL_MON_BIT);
        else if (reg_wr && reg_addr == `REG_CTRL)
            monitor_r <= reg_wdata[`CTRL_MON_BIT];
    end

    // Read data stands for one cycle; unmapped words read as zero.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            reg_rdata <= 32'h0000_0000;
        else if (!reg_rd)
            reg_rdata <= 32'h0000_0000;
        else
        begin
            case (reg_addr)
                `REG_CTRL: reg_rdata <= {31'h0, monitor_r};
                `REG_INDEX: reg_rdata <= {16'h0000, alarm_index_register};
                `REG_FLAGS: reg_rdata <= {27'h0, any_alarm_active_flag, 1'b0,
                    operation_error_flag, borrow_flag, zero_flag};
                4'h3: reg_rdata <= alarm_state[31:0];
                4'h4: reg_rdata <= alarm_state[63:32];
                4'h5: reg_rdata <= alarm_state[95:64];
                `REG_ALARM3: reg_rdata <= {28'h0, alarm_state[99:96]};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule : data_unit

// [data_unit_map.svh]
// Offsets, field positions, limits and timing counts of the data instruction unit.
`ifndef DATA_UNIT_MAP_SVH
`define DATA_UNIT_MAP_SVH

// ----------------------------------------
// Register word addresses
// ----------------------------------------
`define REG_CTRL 4'h0
`define REG_INDEX 4'h1
`define REG_FLAGS 4'h2
`define REG_ALARM0 4'h3
`define REG_ALARM3 4'h6

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define CTRL_MON_BIT 0
`define CTRL_RESET 32'h0000_0000
`define FLAG_ZERO_BIT 0
`define FLAG_BORROW_BIT 1
`define FLAG_OPERR_BIT 2
`define FLAG_INSTERR_BIT 3
`define FLAG_ANY_BIT 4

// ----------------------------------------
// Operand limits
// ----------------------------------------
`define MEAN_MAX 7'h40
`define DEV_WORDS 16'h1F40
`define TIMER_COUNT 200
`define TIMER_LAST 8'hC7
`define ALARM_COUNT 100
`define ALARM_LAST 7'h63
`define ALARM_BASE 16'h0384
`define PRESET_MAX 16'h7FFF
`define BIT_MAX_NARROW 6'h0F
`define BIT_MAX_WIDE 6'h1F

// ----------------------------------------
// Timing
// ----------------------------------------
`define TICK_MS 100
`define CLOCK_KHZ 10000
`define TICK_CYCLES (`TICK_MS * `CLOCK_KHZ)

`endif

// [data_unit_pkg.sv]
// Types shared by the data instruction unit modules.
package data_unit_pkg;

    // Operation selected by the scan engine.
    typedef enum logic [2:0] {
        OP_BIT_JUDGE = 3'h0,
        OP_MEAN = 3'h1,
        OP_ALARM_SET = 3'h2,
        OP_ALARM_RESET = 3'h3,
        OP_SQUARE_ROOT = 3'h4,
        OP_INT_TO_FLOAT = 3'h5
    } op_code_t;

    // Sequencer states of the unit.
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_MEAN = 2'h1,
        ST_SQRT = 2'h2
    } unit_state_t;

endpackage : data_unit_pkg

// [data_unit_if.sv]
// Carriers between the unit sequencer and its arithmetic helpers.
`timescale 1ns/1ps

// ----------------------------------------
// Square root request and answer
// ----------------------------------------
interface sqrt_if;
    logic start;
    logic [31:0] radicand;
    logic done;
    logic [15:0] root;
    logic inexact;
    modport requester (output start, output radicand, input done, input root, input inexact);
    modport solver (input start, input radicand, output done, output root, output inexact);
endinterface : sqrt_if

// ----------------------------------------
// Integer to float conversion
// ----------------------------------------
interface float_if;
    logic [31:0] value;
    logic [31:0] result;
    modport requester (output value, input result);
    modport converter (input value, output result);
endinterface : float_if

// [int_sqrt.sv]
// Iterative integer square root, one result bit per clock.
`timescale 1ns/1ps

module int_sqrt (
    input wire logic clock, // System clock.
    input wire logic rst, // Asynchronous reset, active high.
    sqrt_if.solver sq // Request and answer.
);
    logic [31:0] rem_r;
    logic [31:0] root_r;
    logic [31:0] one_r;
    logic busy_r;
    logic [31:0] trial;

    assign trial = root_r + one_r;

    // ----------------------------------------
    // Digit recurrence
    // ----------------------------------------
    // Restoring method: sixteen steps, no multiplier needed.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            rem_r <= 32'h0000_0000;
            root_r <= 32'h0000_0000;
            one_r <= 32'h0000_0000;
            busy_r <= 1'b0;
        end
        else if (sq.start)
        begin
            rem_r <= sq.radicand;
            root_r <= 32'h0000_0000;
            one_r <= 32'h4000_0000;
            busy_r <= 1'b1;
        end
        else if (busy_r)
        begin
            if (rem_r >= trial)
            begin
                rem_r <= rem_r - trial;
                root_r <= (root_r >> 1) + one_r;
            end
            else
            begin
                root_r <= root_r >> 1;
            end
            one_r <= one_r >> 2;
            busy_r <= (one_r != 32'h0000_0001);
        end
    end

    // Answer is valid the cycle after the last step.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            sq.done <= 1'b0;
        else
            sq.done <= busy_r && (one_r == 32'h0000_0001);
    end

    assign sq.root = root_r[15:0];
    assign sq.inexact = (rem_r != 32'h0000_0000);
endmodule : int_sqrt

// [int_to_float.sv]
// Signed 32-bit integer to single-precision float, truncating extra bits.
`timescale 1ns/1ps

module int_to_float (
    float_if.converter cv // Value in, float out.
);
    logic sign;
    logic [31:0] mag;
    logic [4:0] msb;
    logic [31:0] norm;
    logic [7:0] expo;

    // ----------------------------------------
    // Normalise and pack
    // ----------------------------------------
    // Magnitude of the most negative value still fits 32 unsigned bits.
    always_comb
    begin
        sign = cv.value[31];
        mag = sign ? (~cv.value + 32'h0000_0001) : cv.value;
        msb = 5'h00;
        for (int i = 0; i < 32; i++)
        begin
            if (mag[i])
                msb = 5'(i);
        end
        norm = mag << (5'h1F - msb);
        expo = 8'h7F + {3'h0, msb};
        if (mag == 32'h0000_0000)
            cv.result = 32'h0000_0000;
        else
            cv.result = {sign, expo, norm[30:8]};
    end
endmodule : int_to_float

// [data_unit_props.sv]
// Port checker for the data instruction unit.
`timescale 1ns/1ps
`include "data_unit_map.svh"
module data_unit_props (
    input wire logic clock, // Clock.
    input wire logic rst, // Reset.
    input wire logic op_start, // Request.
    input wire logic [2:0] op_code, // Selector.
    input wire logic op_drive, // Drive.
    input wire logic op_pulse, // Pulse form.
    input wire logic op_wide, // Wide form.
    input wire logic [31:0] op_src, // Source.
    input wire logic [15:0] op_arg, // Argument.
    input wire logic done, // Finished.
    input wire logic wr_word, // Word write.
    input wire logic wr_bit, // Bit write.
    input wire logic instr_error, // Bad operand.
    input wire logic operation_error_flag, // Negative root.
    input wire logic any_alarm_active_flag, // Any alarm.
    input wire logic [15:0] alarm_index_register, // Lowest alarm.
    input wire logic [`ALARM_COUNT-1:0] alarm_state // States.
);
    logic go;
    logic [15:0] lowest;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // A driven continuous request always fires, so it is the safe trigger.
    assign go = op_start && op_drive && !op_pulse;
    // Lowest active state number, scanned from the top so the last hit wins.
    always_comb
    begin
        lowest = 16'h0000;
        for (int i = `ALARM_COUNT - 1; i >= 0; i--)
            if (alarm_state[i])
                lowest = 16'h0384 + 16'(i);
    end
    property p_bit; go && op_code == 3'h0 && !op_wide && op_arg > 16'h000F |=> instr_error; endproperty
    a_bit: assert property (p_bit) else $error("bit index accepted");
    property p_cnt; go && op_code == 3'h1 && (op_arg == 16'h0 || op_arg > 16'h40) |=> instr_error && !wr_word; endproperty
    a_cnt: assert property (p_cnt) else $error("mean count accepted");
    property p_neg; go && op_code == 3'h4 && op_wide && op_src[31]
        |=> done ##0 (operation_error_flag && !wr_word) [*2]; endproperty
    a_neg: assert property (p_neg) else $error("negative root ran");
    property p_none; !(|alarm_state) && !(|$past(alarm_state)) |-> !any_alarm_active_flag; endproperty
    a_none: assert property (p_none) else $error("alarm flag without alarm");
    property p_idx; any_alarm_active_flag && $stable(alarm_state) && alarm_state == $past(alarm_state, 2) |-> alarm_index_register == lowest; endproperty
    a_idx: assert property (p_idx) else $error("alarm index wrong");
    property p_clr; go && op_code == 3'h3 && |alarm_state |=> alarm_state == ($past(alarm_state) & ($past(alarm_state) - 1'b1)); endproperty
    a_clr: assert property (p_clr) else $error("alarm reset cleared wrong state");
    property p_root; go && op_code == 3'h4 && op_wide && !op_src[31] |-> ##[1:20] done && wr_word; endproperty
    a_root: assert property (p_root) else $error("root not stored");
    property p_off; op_start && !op_drive |=> !wr_word && !wr_bit; endproperty
    a_off: assert property (p_off) else $error("write without drive");
endmodule : data_unit_props

bind data_unit data_unit_props i_props (.*);

// [dev_mem.sv]
// Device word memory answering the unit's read strobe.
`timescale 1ns/1ps
module dev_mem (
    input wire logic clock, // Clock.
    input wire logic mem_rd, // Read strobe.
    input wire logic [15:0] mem_addr, // Word address.
    output logic [31:0] mem_rdata // Read data.
);
    // Word A holds minus (A + 1); other cycles show toggled stale data.
    always_ff @(posedge clock)
        mem_rdata <= mem_rd ? {16'hFFFF, ~mem_addr} : ~mem_rdata;
endmodule : dev_mem

// [data_unit_tb_top.sv]
// Self-checking bench of the data instruction unit.
`timescale 1ns/1ps
`include "data_unit_map.svh"
module data_unit_tb_top;
    logic clock = 1'b0, rst = 1'b1;
    logic op_start = 1'b0, op_drive = 1'b0, op_pulse = 1'b0, op_wide = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic [2:0] op_code = 3'h0;
    logic [7:0] op_slot = 8'h00;
    logic [6:0] op_target = 7'h00;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] op_arg = 16'h0, op_addr = 16'h0, mem_addr, alarm_index_register;
    logic [31:0] op_src = 32'h0, reg_wdata = 32'h0, mem_rdata, res_word, reg_rdata;
    logic mem_rd, done, wr_word, wr_bit, res_bit, instr_error, borrow_flag, zero_flag;
    logic operation_error_flag, any_alarm_active_flag;
    logic [`ALARM_COUNT-1:0] alarm_state;
    int n_fail = 0;
    int cmp_count = 0;
    // A short tick keeps alarm presets within a few dozen scans.
    always #50 clock = ~clock;
    data_unit #(.TICK_CYCLES(10)) i_data_unit (.*);
    dev_mem i_dev_mem (.*);

    task automatic chk(input string nm, input logic [35:0] got, exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic rg(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
        if (!w)
            chk("reg", reg_rdata, d);
    endtask : rg

    // One scan of one instruction; f is {wide, pulse, drive}, ad is word, timer and target.
    task automatic op(input logic [2:0] c, f, input logic [31:0] s,
        input logic [15:0] a = 16'h0, ad = 16'h0);
        int k;
        k = 0;
        @(posedge clock);
        op_start <= 1'b1;
        op_code <= c;
        op_slot <= {5'h00, c};
        {op_wide, op_pulse, op_drive} <= f;
        op_src <= s;
        op_arg <= a;
        op_addr <= ad;
        op_target <= ad[6:0];
        @(posedge clock);
        op_start <= 1'b0;
        #1;
        while (done !== 1'b1 && k < 40)
        begin
            @(posedge clock);
            #1;
            k++;
        end
        chk("done", done, 1'b1);
    endtask : op

    task automatic t_bit();
        op(3'h0, 3'h1, 32'h8000, 16'hF);
        chk("b15", res_bit, 1'b1);
        op(3'h0, 3'h5, 32'h7FFF_FFFF, 16'h1F);
        chk("b31", res_bit, 1'b0);
        op(3'h0, 3'h1, 32'h0, 16'h10);
        chk("b16", instr_error, 1'b1);
        op(3'h0, 3'h0, 32'h0);
        chk("idle", wr_bit, 1'b0);
        $display("bit judge test over");
    endtask : t_bit

    task automatic t_mean();
        op(3'h1, 3'h1, 32'h0, 16'h4);
        chk("mean", res_word[15:0], 16'hFFFE);
        op(3'h1, 3'h1, 32'h0, 16'h4, 16'h1F3E);
        chk("end", res_word[15:0], 16'hE0C1);
        op(3'h1, 3'h1, 32'h0, 16'h41);
        chk("n65", instr_error, 1'b1);
        op(3'h1, 3'h1, 32'h0, 16'h0);
        chk("n0", instr_error, 1'b1);
        $display("mean test over");
    endtask : t_mean

    task automatic t_alarm();
        repeat (2)
        begin
            repeat (8) op(3'h2, 3'h1, 32'h0, 16'h3, 16'h1);
            op(3'h2, 3'h0, 32'h0, 16'h3, 16'h1);
        end
        repeat (25) op(3'h2, 3'h1, 32'h0, 16'h3, 16'h5);
        repeat (25) op(3'h2, 3'h1, 32'h0, 16'h3, 16'h3);
        op(3'h2, 3'h0, 32'h0, 16'h3, 16'h3);
        chk("keep", alarm_state[6:0], 7'h28);
        chk("any", any_alarm_active_flag, 1'b1);
        rg(1'b0, 4'h1, 32'h0387);
        op(3'h3, 3'h3, 32'h0);
        op(3'h3, 3'h3, 32'h0);
        chk("once", alarm_state[6:0], 7'h20);
        rg(1'b0, 4'h1, 32'h0389);
        op(3'h3, 3'h1, 32'h0);
        chk("clr", alarm_state[6:0], 7'h00);
        rg(1'b0, 4'hF, 32'h0);
        chk("none", any_alarm_active_flag, 1'b0);
        $display("alarm test over");
    endtask : t_alarm

    task automatic t_sqrt();
        op(3'h4, 3'h5, 32'h0);
        chk("sq0", {zero_flag, res_word}, {1'b1, 32'h0});
        op(3'h4, 3'h5, 32'hA);
        chk("sq10", {zero_flag, borrow_flag, res_word}, {2'h1, 32'h3});
        op(3'h4, 3'h5, 32'h8000_0000);
        chk("neg", {operation_error_flag, res_word}, {1'b1, 32'h3});
        op(3'h5, 3'h1, 32'hFFFE);
        chk("m2", res_word, 32'hC000_0000);
        op(3'h5, 3'h5, 32'h5);
        chk("p5", res_word, 32'h40A0_0000);
        $display("root and float test over");
    endtask : t_sqrt

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results

    // The whole run needs well under a thousand cycles.
    initial
    begin
        #1000000;
        n_fail++;
        results();
    end

    initial
    begin
        repeat (5) @(posedge clock);
        rst <= 1'b0;
        rg(1'b1, 4'h0, 32'h1);
        t_bit();
        t_mean();
        t_alarm();
        t_sqrt();
        results();
    end
endmodule : data_unit_tb_top
